// File: rtl/flash_wel_sec.sv
// Write-enable latch, configuration fields and security register of a serial flash
`timescale 1ns/100ps
// Function
// - Three-bit strength code drives eight impedance steps
// - Dummy code selects clock count per read
// - Erase fail flag follows last erase result
// - Program fail flag follows last program result
// - Erase suspended flag set, cleared on resume
// - Program suspended flag set, cleared on resume
// - Bit zero reports factory lock of area
// - Customer lock bit freezes itself and area
// - Secured area mode blocks main array access
// - Bit seven selects protect mode, one-time
// - Set-latch command sets the write latch
// - Clear-latch command clears the write latch
// - Resets and write completions clear the latch
// - Program and erase need latch set
// - Strength field written by status write command
module flash_wel_sec
  import flash_wel_sec_pkg::*;
#(
  parameter int DRV_STEPS = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Serial link, its own clock domain
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] data_lines_i,
  // Asynchronous pins
  input wire logic reset_pin_n_i,
  input wire logic factory_lock_i,
  // Array engine, same clock as ref_clk_i
  input wire engine_evt_t engine_evt_i,
  output engine_req_t engine_req_o,
  // Status and configuration
  output logic write_enable_latch_o,
  output logic [7:0] security_status_o,
  output logic [2:0] driver_strength_field_o,
  output logic [DRV_STEPS-1:0] driver_legs_o,
  output logic [1:0] dummy_count_field_o,
  output logic [3:0] dummy_fast_o,
  output logic [3:0] dummy_dual_io_o,
  output logic [3:0] dummy_quad_io_o,
  output logic four_line_command_mode_o,
  output logic array_blocked_o
);

  // Link-side state: one pair of sampled line nibbles per two clocks
  typedef struct packed {
    logic [3:0] first_nib;
    logic [7:0] pair;
    logic pair_tgl;
  } link_state_t;

  // Core-side state
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic cs_s4;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic rp_s1;
    logic rp_s2;
    logic fl_s1;
    logic fl_s2;
    logic [7:0] shreg;
    logic [2:0] nbits;
    logic [1:0] nbytes;
    logic [7:0] opcode;
    logic [7:0] status_byte;
    logic [7:0] config_byte;
    logic wel;
    logic [2:0] driver_strength_field;
    logic [1:0] dc;
    logic protect_sel;
    logic erase_fail;
    logic prog_fail;
    logic erase_susp;
    logic prog_susp;
    logic customer_lock;
    logic factory_lock;
    logic otp_mode;
    logic four_line;
    engine_req_t req;
    logic [DRV_STEPS-1:0] legs;
    logic [3:0] dmy_fast;
    logic [3:0] dmy_dual;
    logic [3:0] dmy_quad;
  } core_state_t;

  link_state_t link_q, link_d;
  core_state_t core_q, core_d;
  logic half_q; // Which clock of the current pair; cleared while select is high

  // Link pair counter: cs_n high restarts it, since sclk may stop between frames
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  // Link next state: capture the lines on every rising sclk edge
  always_comb begin
    link_d = link_q;
    if (!half_q) begin
      link_d.first_nib = data_lines_i;
    end else begin
      // Pair stays stable for two sclk periods, long enough for the core to read it
      link_d.pair = {link_q.first_nib, data_lines_i};
      link_d.pair_tgl = ~link_q.pair_tgl;
    end
  end

  // Link registers; select high parks the toggle at zero so it is never unknown.
  // That park step crosses with select itself, so the core drops it as a pair event.
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      link_q.pair_tgl <= 1'b0;
    end else begin
      link_q <= link_d;
    end
  end

  // Core next state
  always_comb begin
    logic pair_evt;
    logic frame_start;
    logic frame_end;
    logic byte_done;
    logic [7:0] new_byte;
    logic [2:0] nbits_n;
    logic [1:0] nbytes_n;
    logic otp_frozen;
    pair_evt = 1'b0;
    frame_start = 1'b0;
    frame_end = 1'b0;
    byte_done = 1'b0;
    new_byte = 8'h00;
    nbits_n = 3'h0;
    nbytes_n = 2'h0;
    otp_frozen = 1'b0;
    core_d = core_q;

    // Synchronisers: first stage feeds only the second
    core_d.cs_s1 = cs_n_i;
    core_d.cs_s2 = core_q.cs_s1;
    core_d.cs_s3 = core_q.cs_s2;
    core_d.cs_s4 = core_q.cs_s3;
    core_d.tg_s1 = link_q.pair_tgl;
    core_d.tg_s2 = core_q.tg_s1;
    core_d.tg_s3 = core_q.tg_s2;
    core_d.rp_s1 = reset_pin_n_i;
    core_d.rp_s2 = core_q.rp_s1;
    core_d.fl_s1 = factory_lock_i;
    core_d.fl_s2 = core_q.fl_s1;

    // Start, suspend and resume requests to the engine are single-cycle pulses; target_otp is a level
    core_d.req = '0;
    core_d.req.target_otp = core_q.otp_mode;

    pair_evt = core_q.tg_s2 ^ core_q.tg_s3;
    frame_start = core_q.cs_s3 && !core_q.cs_s2;
    // End taken one cycle late so a last pair seen together with cs is assembled first
    frame_end = core_q.cs_s3 && !core_q.cs_s4;

    // Opcode assembly: 2 bits per pair on one line, 8 bits on four lines
    if (frame_start) begin
      core_d.nbits = 3'h0;
      core_d.nbytes = 2'h0;
    end else if (pair_evt && !core_q.cs_s2) begin
      if (core_q.four_line) begin
        new_byte = link_q.pair;
        byte_done = 1'b1;
      end else begin
        // Upper lines ignored in single-line mode
        new_byte = {core_q.shreg[5:0], link_q.pair[4], link_q.pair[0]};
        nbits_n = core_q.nbits + 3'h2;
        core_d.nbits = nbits_n;
        core_d.shreg = new_byte;
        byte_done = (nbits_n == 3'h0);
      end
    end

    // Store completed bytes by position in the frame
    if (byte_done) begin
      nbytes_n = (core_q.nbytes == BYTES_WITH_CONFIG) ? core_q.nbytes : core_q.nbytes + 2'h1;
      core_d.nbytes = nbytes_n;
      case (core_q.nbytes)
        2'h0: core_d.opcode = new_byte;
        2'h1: core_d.status_byte = new_byte;
        2'h2: core_d.config_byte = new_byte;
        default: core_d.config_byte = core_q.config_byte;
      endcase
    end

    // Secured area is frozen by either lock
    otp_frozen = core_q.customer_lock || core_q.factory_lock;

    // Commands take effect when the frame closes after whole bytes
    if (frame_end && core_q.nbits == 3'h0 && core_q.nbytes != 2'h0) begin
      case (core_q.opcode)
        OP_SET_WRITE_LATCH: core_d.wel = 1'b1;
        OP_CLEAR_WRITE_LATCH: core_d.wel = 1'b0;
        OP_WRITE_STATUS: begin
          if (core_q.wel && core_q.nbytes >= BYTES_WITH_STATUS) begin
            if (core_q.nbytes == BYTES_WITH_CONFIG) begin
              core_d.driver_strength_field = core_q.config_byte[CFG_ODS_LSB +: 3];
              core_d.dc = core_q.config_byte[CFG_DC_LSB +: 2];
            end
            core_d.wel = 1'b0;
          end
        end
        OP_WRITE_SECURITY: begin
          if (core_q.wel) begin
            // Lock bit only ever goes from zero to one
            if (!core_q.customer_lock) begin
              core_d.customer_lock = 1'b1;
            end
            core_d.wel = 1'b0;
          end
        end
        OP_WRITE_PROTECT_SEL: begin
          if (core_q.wel) begin
            core_d.protect_sel = 1'b1;
            core_d.wel = 1'b0;
          end
        end
        OP_PROGRAM: begin
          // Without the latch, or into a frozen secured area, nothing starts
          if (core_q.wel && !(core_q.otp_mode && otp_frozen)) begin
            core_d.req.prog_start = 1'b1;
          end
        end
        OP_ERASE: begin
          if (core_q.wel && !(core_q.otp_mode && otp_frozen)) begin
            core_d.req.erase_start = 1'b1;
          end
        end
        OP_SUSPEND: core_d.req.suspend_req = 1'b1;
        OP_RESUME: begin
          core_d.req.resume_req = 1'b1;
          // Resuming clears both suspend indications
          core_d.erase_susp = 1'b0;
          core_d.prog_susp = 1'b0;
        end
        OP_ENTER_OTP: core_d.otp_mode = 1'b1;
        OP_EXIT_OTP: core_d.otp_mode = 1'b0;
        OP_ENTER_FOUR_LINE: core_d.four_line = 1'b1;
        OP_EXIT_FOUR_LINE: core_d.four_line = 1'b0;
        OP_SOFT_RESET: begin
          core_d.wel = 1'b0;
          core_d.otp_mode = 1'b0;
          core_d.four_line = 1'b0;
        end
        default: core_d.opcode = core_q.opcode;
      endcase
    end

    // Engine completions; fail flags never stop anything, they only report
    if (engine_evt_i.prog_done) begin
      core_d.prog_fail = !engine_evt_i.prog_ok;
      core_d.wel = 1'b0;
    end
    if (engine_evt_i.erase_done) begin
      core_d.erase_fail = !engine_evt_i.erase_ok;
      core_d.wel = 1'b0;
    end
    if (engine_evt_i.susp_done) begin
      if (engine_evt_i.susp_erase) begin
        core_d.erase_susp = 1'b1;
      end else begin
        core_d.prog_susp = 1'b1;
      end
      core_d.wel = 1'b0;
    end

    // Reset pin low clears the latch and leaves secured mode
    if (!core_q.rp_s2) begin
      core_d.wel = 1'b0;
      core_d.otp_mode = 1'b0;
    end

    // Factory lock follows the synchronised strap
    core_d.factory_lock = core_q.fl_s2;

    // Decoded outputs, registered
    core_d.dmy_fast = DUMMY_FAST_TBL[{core_d.dc, 2'b00} +: 4];
    core_d.dmy_dual = DUMMY_DUAL_IO_TBL[{core_d.dc, 2'b00} +: 4];
    core_d.dmy_quad = DUMMY_QUAD_IO_TBL[{core_d.dc, 2'b00} +: 4];
    core_d.legs = leg_enables(core_d.driver_strength_field);
  end

  // Thermometer of driver legs: code 000 enables one leg, 111 enables all
  function automatic logic [DRV_STEPS-1:0] leg_enables(input logic [2:0] code);
    logic [DRV_STEPS-1:0] legs;
    legs = '0;
    for (int i = 0; i < DRV_STEPS; i++) begin
      legs[i] = (i <= int'(code));
    end
    return legs;
  endfunction

  // Core registers; power-up reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      core_q <= '0;
      core_q.cs_s1 <= 1'b1;
      core_q.cs_s2 <= 1'b1;
      core_q.cs_s3 <= 1'b1;
      core_q.cs_s4 <= 1'b1;
      core_q.rp_s1 <= 1'b1;
      core_q.rp_s2 <= 1'b1;
      core_q.driver_strength_field <= ODS_RESET;
      core_q.dc <= DC_RESET;
      core_q.legs <= '1;
      core_q.dmy_fast <= DUMMY_FAST_TBL[3:0];
      core_q.dmy_dual <= DUMMY_DUAL_IO_TBL[3:0];
      core_q.dmy_quad <= DUMMY_QUAD_IO_TBL[3:0];
      core_q.wel <= 1'b0;
    end else begin
      core_q <= core_d;
    end
  end

  // Outputs straight from flip-flops; bit four is held at zero
  assign engine_req_o = core_q.req;
  assign write_enable_latch_o = core_q.wel;
  assign security_status_o = {core_q.protect_sel, core_q.erase_fail, core_q.prog_fail,
                              1'b0, core_q.erase_susp, core_q.prog_susp,
                              core_q.customer_lock, core_q.factory_lock};
  assign driver_strength_field_o = core_q.driver_strength_field;
  assign driver_legs_o = core_q.legs;
  assign dummy_count_field_o = core_q.dc;
  assign dummy_fast_o = core_q.dmy_fast;
  assign dummy_dual_io_o = core_q.dmy_dual;
  assign dummy_quad_io_o = core_q.dmy_quad;
  assign four_line_command_mode_o = core_q.four_line;
  assign array_blocked_o = core_q.otp_mode;

endmodule

// File: rtl/flash_wel_sec_pkg.sv
// Package: opcodes, field layouts, reset values and tables for the latch and security logic
package flash_wel_sec_pkg;

  // Command opcodes received on the serial link
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_SECURITY = 8'h2F;
  localparam logic [7:0] OP_WRITE_PROTECT_SEL = 8'h68;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE = 8'h20;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam logic [7:0] OP_ENTER_OTP = 8'hB1;
  localparam logic [7:0] OP_EXIT_OTP = 8'hC1;
  localparam logic [7:0] OP_ENTER_FOUR_LINE = 8'h35;
  localparam logic [7:0] OP_EXIT_FOUR_LINE = 8'hF5;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;

  // Security register bit positions
  localparam int SEC_FACTORY_LOCK = 0;
  localparam int SEC_CUSTOMER_LOCK = 1;
  localparam int SEC_PROG_SUSP = 2;
  localparam int SEC_ERASE_SUSP = 3;
  localparam int SEC_PROG_FAIL = 5;
  localparam int SEC_ERASE_FAIL = 6;
  localparam int SEC_PROTECT_SEL = 7;

  // Configuration byte field positions
  localparam int CFG_ODS_LSB = 0;
  localparam int CFG_DC_LSB = 6;

  // Reset values
  localparam logic [2:0] ODS_RESET = 3'h7;
  localparam logic [1:0] DC_RESET = 2'h0;

  // Frame byte counts: opcode, status byte, configuration byte
  localparam logic [1:0] BYTES_WITH_STATUS = 2'h2;
  localparam logic [1:0] BYTES_WITH_CONFIG = 2'h3;

  // Dummy clock counts per code, code 11 in the top nibble
  localparam logic [15:0] DUMMY_FAST_TBL = 16'hA868;
  localparam logic [15:0] DUMMY_DUAL_IO_TBL = 16'hA864;
  localparam logic [15:0] DUMMY_QUAD_IO_TBL = 16'hA846;

  // Event from the array engine that finished an operation
  typedef struct packed {
    logic prog_done;
    logic prog_ok;
    logic erase_done;
    logic erase_ok;
    logic susp_done;
    logic susp_erase;
  } engine_evt_t;

  // Start, suspend and resume requests toward the array engine, plus the target_otp level
  typedef struct packed {
    logic prog_start;
    logic erase_start;
    logic target_otp;
    logic suspend_req;
    logic resume_req;
  } engine_req_t;

endpackage

// File: tb/flash_wel_sec_monitor.sv
// Checker for the latch, configuration and security outputs of the flash block
`timescale 1ns/100ps
module flash_wel_sec_monitor
  import flash_wel_sec_pkg::*;
#(
  parameter int DRV_STEPS = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire engine_evt_t engine_evt_i,
  input wire engine_req_t engine_req_o,
  input wire logic write_enable_latch_o,
  input wire logic [7:0] security_status_o,
  input wire logic [2:0] driver_strength_field_o,
  input wire logic [DRV_STEPS-1:0] driver_legs_o,
  input wire logic [1:0] dummy_count_field_o,
  input wire logic [3:0] dummy_fast_o,
  input wire logic [3:0] dummy_dual_io_o,
  input wire logic [3:0] dummy_quad_io_o,
  input wire logic array_blocked_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Completion events from the array engine
  sequence s_prog_end;
    engine_evt_i.prog_done;
  endsequence
  sequence s_erase_end;
    engine_evt_i.erase_done;
  endsequence
  sequence s_any_end;
    engine_evt_i.prog_done || engine_evt_i.erase_done || engine_evt_i.susp_done;
  endsequence
  // One-time bits must survive; the reset sample is skipped on purpose
  property p_sticky(int b);
    $past(security_status_o[b]) && !$past(srst_i) |-> security_status_o[b];
  endproperty
  chk_legs_thermo: assert property (driver_legs_o ==
    DRV_STEPS'((32'h1 << (driver_strength_field_o + 4'h1)) - 1))
    else $error("driver legs do not match strength code");
  chk_dummy_fast: assert property (dummy_fast_o ==
    DUMMY_FAST_TBL[{dummy_count_field_o, 2'b00} +: 4])
    else $error("fast read dummy count wrong");
  chk_dummy_io: assert property ({dummy_dual_io_o, dummy_quad_io_o} ==
    {DUMMY_DUAL_IO_TBL[{dummy_count_field_o, 2'b00} +: 4],
     DUMMY_QUAD_IO_TBL[{dummy_count_field_o, 2'b00} +: 4]})
    else $error("io read dummy count wrong");
  chk_prog_fail: assert property (s_prog_end |=>
    security_status_o[SEC_PROG_FAIL] == !$past(engine_evt_i.prog_ok))
    else $error("program fail flag wrong");
  chk_erase_fail: assert property (s_erase_end |=>
    security_status_o[SEC_ERASE_FAIL] == !$past(engine_evt_i.erase_ok))
    else $error("erase fail flag wrong");
  chk_latch_done: assert property (s_any_end |=> !write_enable_latch_o)
    else $error("latch not cleared on completion");
  chk_susp_flag: assert property (engine_evt_i.susp_done |=>
    security_status_o[$past(engine_evt_i.susp_erase) ? 3 : 2])
    else $error("suspend flag not raised");
  chk_start_latch: assert property (engine_req_o.prog_start || engine_req_o.erase_start
    |-> $past(write_enable_latch_o))
    else $error("start without write latch");
  chk_lock_sticky: assert property (p_sticky(SEC_CUSTOMER_LOCK))
    else $error("customer lock bit changed");
  chk_psel_sticky: assert property (p_sticky(SEC_PROTECT_SEL))
    else $error("protect select bit changed");
  chk_resv_zero: assert property (!security_status_o[4])
    else $error("reserved bit set");
  chk_otp_target: assert property (engine_req_o.target_otp == $past(array_blocked_o))
    else $error("secured area target does not follow secured mode");
endmodule
bind flash_wel_sec flash_wel_sec_monitor #(.DRV_STEPS(DRV_STEPS)) mon (.ref_clk_i, .srst_i,
  .engine_evt_i, .engine_req_o, .write_enable_latch_o, .security_status_o,
  .driver_strength_field_o, .driver_legs_o, .dummy_count_field_o, .dummy_fast_o,
  .dummy_dual_io_o, .dummy_quad_io_o, .array_blocked_o);

// File: tb/host_link_model.sv
// Host side of the serial command link: frames bytes on its own clock
`timescale 1ns/100ps
module host_link_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] data_o
);
  // A late first rise of select puts the link side into its idle state
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    data_o = 4'h0;
    #10;
    cs_n_o = 1'b1;
  end
  // Clock runs only inside a frame; lines toggle once released
  task automatic send(input logic [23:0] frame, input int nbytes, input logic quad);
    int i;
    cs_n_o = 1'b0;
    #37;
    for (i = 0; i < nbytes * 8; i += (quad ? 4 : 1)) begin
      // Spare lines carry junk in single-line mode
      if (quad) data_o = frame[23 - i -: 4];
      else data_o = {~data_o[3:1], frame[23 - i]};
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    #20 cs_n_o = 1'b1;
    data_o = ~data_o;
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the write latch, configuration and security logic
`timescale 1ns/100ps
module testbench;
  import flash_wel_sec_pkg::*;
  logic ref_clk_i, srst_i, reset_pin_n_i, factory_lock_i;
  wire logic sclk_i, cs_n_i;
  wire logic [3:0] data_lines_i;
  engine_evt_t engine_evt_i;
  engine_req_t engine_req_o;
  logic write_enable_latch_o, four_line_command_mode_o, array_blocked_o;
  logic [7:0] security_status_o, driver_legs_o;
  logic [2:0] driver_strength_field_o;
  logic [1:0] dummy_count_field_o;
  logic [3:0] dummy_fast_o, dummy_dual_io_o, dummy_quad_io_o;
  // Expected state kept by the bench
  logic e_wel = 0, e_fl = 0, e_blk = 0;
  logic [7:0] e_sec = 8'h00;
  logic [2:0] e_ods = 3'h7;
  logic [1:0] e_dc = 2'h0;
  logic [3:0] e_np = 0, e_ne = 0, e_ns = 0, e_nr = 0, n_p = 0, n_e = 0, n_s = 0, n_r = 0;
  logic [3:0] fast_t [4] = '{4'h8, 4'h6, 4'h8, 4'hA};
  logic [3:0] dual_t [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
  logic [3:0] quad_t [4] = '{4'h6, 4'h4, 4'h8, 4'hA};
  logic [51:0] exp_q [$];
  int miscompares = 0, samples_checked = 0, i;
  logic [31:0] seed_v;
  wire logic [51:0] obs = {write_enable_latch_o, security_status_o, driver_strength_field_o,
    driver_legs_o, dummy_count_field_o, dummy_fast_o, dummy_dual_io_o, dummy_quad_io_o,
    four_line_command_mode_o, array_blocked_o, n_p, n_e, n_s, n_r};
  flash_wel_sec dut (.ref_clk_i, .srst_i, .sclk_i, .cs_n_i, .data_lines_i, .reset_pin_n_i,
    .factory_lock_i, .engine_evt_i, .engine_req_o, .write_enable_latch_o,
    .security_status_o, .driver_strength_field_o, .driver_legs_o, .dummy_count_field_o,
    .dummy_fast_o, .dummy_dual_io_o, .dummy_quad_io_o, .four_line_command_mode_o,
    .array_blocked_o);
  host_link_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .data_o(data_lines_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // Count start, suspend and resume pulses toward the engine
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      {n_p, n_e, n_s, n_r} <= 16'h0000;
    end else begin
      n_p <= n_p + engine_req_o.prog_start;
      n_e <= n_e + engine_req_o.erase_start;
      n_s <= n_s + engine_req_o.suspend_req;
      n_r <= n_r + engine_req_o.resume_req;
    end
  end
  task automatic check(input logic [51:0] seen, input logic [51:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // Watcher takes the oldest note once outputs have settled
  always @(negedge ref_clk_i) begin
    if (exp_q.size() > 0) check(obs, exp_q.pop_front());
  end
  task automatic conclude();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic settle();
    repeat (10) @(negedge ref_clk_i);
  endtask
  task automatic note();
    exp_q.push_back({e_wel, e_sec, e_ods, 8'hFF >> (3'h7 - e_ods), e_dc, fast_t[e_dc],
      dual_t[e_dc], quad_t[e_dc], e_fl, e_blk, e_np, e_ne, e_ns, e_nr});
    repeat (2) @(negedge ref_clk_i);
  endtask
  task automatic xfer(input logic [23:0] f, input int n);
    host.send(f, n, e_fl);
    settle();
  endtask
  task automatic cmd(input logic [7:0] op);
    xfer({op, 16'h0000}, 1);
  endtask
  // One-cycle completion pulse from the engine
  task automatic evt(input logic [5:0] e);
    engine_evt_i = engine_evt_t'(e);
    @(negedge ref_clk_i);
    engine_evt_i = '0;
    settle();
  endtask
  initial begin
    #1000000;
    miscompares++;
    conclude();
  end
  initial begin
    seed_v = $urandom(32'h3F26);
    srst_i = 1'b1;
    reset_pin_n_i = 1'b1;
    factory_lock_i = 1'b0;
    engine_evt_i = '0;
    repeat (6) @(negedge ref_clk_i);
    srst_i = 1'b0;
    settle();
    note();
    factory_lock_i = 1'b1;
    e_sec[0] = 1'b1;
    settle();
    note();
    xfer({OP_WRITE_STATUS, 16'h1200}, 3);
    note();
    // Every strength and dummy code, last half in four-line mode
    for (i = 0; i < 8; i++) begin
      if (i == 4) begin
        cmd(OP_ENTER_FOUR_LINE);
        e_fl = 1'b1;
      end
      cmd(OP_SET_WRITE_LATCH);
      e_wel = 1'b1;
      note();
      xfer({OP_WRITE_STATUS, 8'($urandom), 2'(i), 3'($urandom), 3'(i)}, 3);
      e_wel = 1'b0;
      e_ods = 3'(i);
      e_dc = 2'(i);
      note();
    end
    cmd(OP_EXIT_FOUR_LINE);
    e_fl = 1'b0;
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_CLEAR_WRITE_LATCH);
    cmd(OP_PROGRAM);
    note();
    // Program and erase, failing then succeeding
    for (i = 0; i < 4; i++) begin
      cmd(OP_SET_WRITE_LATCH);
      cmd(i[1] ? OP_ERASE : OP_PROGRAM);
      if (i[1]) e_ne++;
      else e_np++;
      evt(i[1] ? {2'b00, 1'b1, i[0], 2'b00} : {1'b1, i[0], 4'h0});
      e_sec[i[1] ? 6 : 5] = !i[0];
      note();
    end
    for (i = 0; i < 2; i++) begin
      cmd(OP_SET_WRITE_LATCH);
      cmd(OP_SUSPEND);
      e_ns++;
      evt({4'h0, 1'b1, i[0]});
      e_sec[i[0] ? 3 : 2] = 1'b1;
      note();
      cmd(OP_RESUME);
      e_nr++;
      e_sec[i[0] ? 3 : 2] = 1'b0;
      note();
    end
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_WRITE_PROTECT_SEL);
    e_sec[7] = 1'b1;
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_WRITE_SECURITY);
    e_sec[1] = 1'b1;
    note();
    cmd(OP_ENTER_OTP);
    e_blk = 1'b1;
    cmd(OP_SET_WRITE_LATCH);
    e_wel = 1'b1;
    note();
    cmd(OP_PROGRAM);
    cmd(OP_SOFT_RESET);
    e_wel = 1'b0;
    e_blk = 1'b0;
    note();
    cmd(OP_SET_WRITE_LATCH);
    e_wel = 1'b1;
    note();
    reset_pin_n_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    reset_pin_n_i = 1'b1;
    e_wel = 1'b0;
    settle();
    note();
    conclude();
  end
endmodule
